/* File: hdl/fapi_dispatch.v */
/*
 * flash maintenance command dispatcher: takes a call to the shared entry
 * routine with command, address and data, runs it on the array and the
 * special cells, and returns the result byte.
 * assumes the caller holds its inputs stable while busy is high.
 */
`timescale 1ns/100ps
`include "fapi_defs.vh"

// Operation
// [R1] all operations start from one call strobe tied to the fixed entry address
// [R2] command, address and data sampled at call; result left in output register
// [R3] result zero on success, non-zero on failure unless a command says otherwise
// [R4] 02h or 92h programs one array byte at the given address
// [R5] 01h or 93h erases the block chosen by upper address bits 7:5
// [R6] block codes 00h, 20h, 40h, 80h, C0h select blocks zero to four
// [R7] 04h erases boot vector and status byte, reports pass or fail
// [R8] 05h programs a lock bit chosen by lower byte; no result returned
// [R9] 60h writes the data byte into the status byte when lower byte is 00h
// [R10] 06h with lower byte 01h writes only the boot vector upper byte
// [R11] 03h reads the array byte at the given address
// [R12] 00h returns maker or device code chosen by the lower byte
// [R13] 07h lower byte 00h returns lock bits in result bits 3:1
// [R14] 07h lower byte 01h gives status byte, 02h gives boot vector byte
// [R15] 90h programs every byte of the selected block to zero
// [R16] 91h erases chip; 55h returns, AAh resets chip, others are errors
// [R17] 94h programs the special cell at the given address from the data byte
// [R18] 95h erases a special cell at 0000h to 0004h and reports outcome
// [R19] 96h reads configuration, identification or lock bit special cells
// [R20] unknown commands touch nothing and return a non-zero failure value
module fapi_dispatch (
    // clock and reset
    input wire clk,
    input wire rst,
    // call from the processor
    input wire call,
    input wire [15:0] call_target,
    input wire [7:0] command_code_reg,
    input wire [15:0] address_param_reg,
    input wire [7:0] data_result_byte,
    // answer
    output wire busy,
    output reg done,
    output reg [7:0] result_q,
    output reg chip_reset_req,
    // special cell state
    output reg [15:0] boot_vector,
    output reg [15:0] boot_status_word,
    output reg [7:0] status_byte,
    output reg lock_bit_one,
    output reg lock_bit_two,
    output reg lock_bit_three
);

    localparam S_IDLE = 4'b0001;
    localparam S_EXEC = 4'b0010;
    localparam S_SWEEP = 4'b0100;
    localparam S_DONE = 4'b1000;

    reg [7:0] flash_mem [0:`FAPI_MEM_DEPTH-1];
    reg [3:0] state_q;
    reg [7:0] cmd_q;
    reg [15:0] addr_q;
    reg [7:0] data_q;
    reg [15:0] ptr_q;
    reg [15:0] last_q;
    reg [7:0] fill_q;
    reg [3:0] pulse_q;
    reg chip_rst_pend_q;
    reg [7:0] rd_q;
    wire [15:0] blk_first;
    wire [15:0] blk_last;
    wire blk_valid;
    wire [7:0] upper_address_byte;
    wire [7:0] lower_address_byte;
    wire lock_any;

    assign upper_address_byte = addr_q[15:8];
    assign lower_address_byte = addr_q[7:0];
    assign lock_any = lock_bit_one;
    assign busy = (state_q != S_IDLE);

    fapi_blk_range u_range (
        .sel(upper_address_byte),
        .first(blk_first),
        .last(blk_last),
        .valid(blk_valid)
    );

    // array read port, registered as a synchronous ram would be
    always @(posedge clk) begin
        rd_q <= flash_mem[addr_q]; // R11
    end

    // array write port for single bytes and sweeps
    always @(posedge clk) begin
        if (state_q == S_EXEC && !lock_any &&
            (cmd_q == `FAPI_CMD_PROG_BYTE || cmd_q == `FAPI_CMD_PROG_BYTE2)) begin
            flash_mem[addr_q] <= data_q; // R4
        end else if (state_q == S_SWEEP && pulse_q == 4'h0 && cmd_q != `FAPI_CMD_READ_BYTE) begin
            flash_mem[ptr_q] <= fill_q; // R5 R15 R16
        end
    end

    // dispatcher sequence
    always @(posedge clk) begin
        if (rst) begin
            state_q <= S_IDLE;
            cmd_q <= 8'h00;
            addr_q <= 16'h0000;
            data_q <= 8'h00;
            ptr_q <= 16'h0000;
            last_q <= 16'h0000;
            fill_q <= 8'h00;
            pulse_q <= 4'h0;
            chip_rst_pend_q <= 1'b0;
            done <= 1'b0;
            result_q <= 8'h00;
            chip_reset_req <= 1'b0;
            boot_vector <= `FAPI_RST_BV;
            boot_status_word <= `FAPI_RST_BSW;
            status_byte <= `FAPI_RST_STAT;
            lock_bit_one <= 1'b0;
            lock_bit_two <= 1'b0;
            lock_bit_three <= 1'b0;
        end else begin
            done <= 1'b0;
            chip_reset_req <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    // a call elsewhere is not ours to answer
                    if (call && call_target == `FAPI_ENTRY_ADDR) begin // R1
                        cmd_q <= command_code_reg; // R2
                        addr_q <= address_param_reg; // R2
                        data_q <= data_result_byte; // R2
                        state_q <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    state_q <= S_DONE;
                    result_q <= `FAPI_PASS; // R3
                    case (cmd_q)
                        `FAPI_CMD_PROG_BYTE, `FAPI_CMD_PROG_BYTE2: begin
                            if (lock_any) begin
                                result_q <= `FAPI_FAIL; // R3
                            end
                        end
                        `FAPI_CMD_ERASE_BLK, `FAPI_CMD_ERASE_BLK2, `FAPI_CMD_ZERO_BLK: begin
                            // bad selection or write lock fails with no array change
                            if (!blk_valid || lower_address_byte != 8'h00 || lock_any) begin
                                result_q <= `FAPI_FAIL; // R6
                            end else begin
                                ptr_q <= blk_first; // R5 R15
                                last_q <= blk_last;
                                fill_q <= (cmd_q == `FAPI_CMD_ZERO_BLK) ? 8'h00 : `FAPI_ERASED;
                                pulse_q <= `FAPI_PULSE_CYC;
                                state_q <= S_SWEEP;
                            end
                        end
                        `FAPI_CMD_ERASE_BVSB: begin
                            boot_vector <= `FAPI_RST_BV; // R7
                            status_byte <= `FAPI_ERASED; // R7
                        end
                        `FAPI_CMD_PROG_LOCK: begin
                            // no result defined, data byte returned untouched
                            result_q <= data_q; // R8
                            case (lower_address_byte)
                                8'h00: lock_bit_one <= 1'b1; // R8
                                8'h01: lock_bit_two <= 1'b1;
                                8'h02: lock_bit_three <= 1'b1;
                                default: result_q <= data_q;
                            endcase
                        end
                        `FAPI_CMD_PROG_STAT: begin
                            if (lower_address_byte == 8'h00) begin
                                status_byte <= data_q; // R9
                            end else begin
                                result_q <= `FAPI_FAIL;
                            end
                        end
                        `FAPI_CMD_PROG_BVH: begin
                            if (lower_address_byte == 8'h01) begin
                                boot_vector <= {data_q, boot_vector[7:0]}; // R10
                            end else begin
                                result_q <= `FAPI_FAIL;
                            end
                        end
                        `FAPI_CMD_READ_BYTE: begin
                            // wait one cycle for the registered array read
                            result_q <= 8'h00;
                            state_q <= S_SWEEP;
                            pulse_q <= 4'h0;
                            ptr_q <= 16'h0000;
                            last_q <= 16'h0000;
                            fill_q <= 8'h00;
                        end
                        `FAPI_CMD_READ_ID: begin
                            case (lower_address_byte)
                                8'h00: result_q <= `FAPI_ID_MAKER; // R12
                                8'h01: result_q <= `FAPI_ID_DEV1;
                                8'h02: result_q <= `FAPI_ID_DEV2;
                                default: result_q <= `FAPI_FAIL;
                            endcase
                        end
                        `FAPI_CMD_READ_MISC: begin
                            case (lower_address_byte)
                                8'h00: result_q <= {4'h0, lock_bit_three, lock_bit_two,
                                                    lock_bit_one, 1'b0}; // R13
                                8'h01: result_q <= status_byte; // R14
                                8'h02: result_q <= boot_vector[15:8]; // R14
                                default: result_q <= `FAPI_FAIL;
                            endcase
                        end
                        `FAPI_CMD_ERASE_CHIP: begin
                            if (data_q == `FAPI_CHIP_RETURN || data_q == `FAPI_CHIP_RESET) begin
                                chip_rst_pend_q <= (data_q == `FAPI_CHIP_RESET); // R16
                                ptr_q <= 16'h0000;
                                last_q <= 16'hffff;
                                fill_q <= `FAPI_ERASED;
                                pulse_q <= `FAPI_PULSE_CYC;
                                state_q <= S_SWEEP;
                                boot_vector <= `FAPI_RST_BV;
                                boot_status_word <= `FAPI_RST_BSW;
                                status_byte <= `FAPI_RST_STAT;
                                lock_bit_one <= 1'b0;
                                lock_bit_two <= 1'b0;
                                lock_bit_three <= 1'b0;
                            end else begin
                                result_q <= `FAPI_FAIL; // R16
                            end
                        end
                        `FAPI_CMD_PROG_CELL: begin
                            case (addr_q)
                                `FAPI_CELL_BSW_LO: boot_status_word[7:0] <= data_q; // R17
                                `FAPI_CELL_BSW_HI: boot_status_word[15:8] <= data_q;
                                `FAPI_CELL_BV_LO: boot_vector[7:0] <= data_q;
                                `FAPI_CELL_BV_HI: boot_vector[15:8] <= data_q;
                                `FAPI_CELL_STAT: status_byte <= data_q;
                                `FAPI_CELL_LOCK1: lock_bit_one <= data_q[0];
                                `FAPI_CELL_LOCK2: lock_bit_two <= data_q[0];
                                `FAPI_CELL_LOCK3: lock_bit_three <= data_q[0];
                                default: result_q <= `FAPI_FAIL;
                            endcase
                        end
                        `FAPI_CMD_ERASE_CELL: begin
                            case (addr_q)
                                `FAPI_CELL_BSW_LO: boot_status_word[7:0] <= `FAPI_ERASED; // R18
                                `FAPI_CELL_BSW_HI: boot_status_word[15:8] <= `FAPI_ERASED;
                                `FAPI_CELL_BV_LO: boot_vector[7:0] <= `FAPI_ERASED;
                                `FAPI_CELL_BV_HI: boot_vector[15:8] <= `FAPI_ERASED;
                                `FAPI_CELL_STAT: status_byte <= `FAPI_ERASED;
                                default: result_q <= `FAPI_FAIL; // R18
                            endcase
                        end
                        `FAPI_CMD_READ_CELL: begin
                            case (addr_q)
                                `FAPI_CELL_BSW_LO: result_q <= boot_status_word[7:0]; // R19
                                `FAPI_CELL_BSW_HI: result_q <= boot_status_word[15:8];
                                `FAPI_CELL_BV_LO: result_q <= boot_vector[7:0];
                                `FAPI_CELL_BV_HI: result_q <= boot_vector[15:8];
                                `FAPI_CELL_STAT: result_q <= status_byte;
                                `FAPI_CELL_MAKER: result_q <= `FAPI_ID_MAKER;
                                `FAPI_CELL_DEV1: result_q <= `FAPI_ID_DEV1;
                                `FAPI_CELL_DEV2: result_q <= `FAPI_ID_DEV2;
                                `FAPI_CELL_LOCK1: result_q <= {7'h00, lock_bit_one};
                                `FAPI_CELL_LOCK2: result_q <= {7'h00, lock_bit_two};
                                `FAPI_CELL_LOCK3: result_q <= {7'h00, lock_bit_three};
                                default: result_q <= `FAPI_FAIL;
                            endcase
                        end
                        default: begin
                            result_q <= `FAPI_BAD_CMD; // R20
                        end
                    endcase
                end
                S_SWEEP: begin
                    // read command only passes through here to catch the array data
                    if (cmd_q == `FAPI_CMD_READ_BYTE) begin
                        result_q <= rd_q; // R11
                        state_q <= S_DONE;
                    end else if (pulse_q != 4'h0) begin
                        pulse_q <= pulse_q - 4'h1;
                    end else if (ptr_q == last_q) begin
                        state_q <= S_DONE;
                    end else begin
                        ptr_q <= ptr_q + 16'h0001;
                    end
                end
                S_DONE: begin
                    done <= 1'b1;
                    state_q <= S_IDLE;
                    // chip reset request goes out in the same cycle as done
                    chip_reset_req <= chip_rst_pend_q; // R16
                    chip_rst_pend_q <= 1'b0;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule

/* File: hdl/fapi_defs.vh */
/*
 * constants for the flash maintenance command dispatcher: entry address,
 * command codes, selections, special cell addresses, result codes, timing.
 * assumes inclusion by bare name from the design files.
 */
`ifndef FAPI_DEFS_VH
`define FAPI_DEFS_VH

`define FAPI_ENTRY_ADDR 16'hfff0
// command codes
`define FAPI_CMD_READ_ID 8'h00
`define FAPI_CMD_ERASE_BLK 8'h01
`define FAPI_CMD_PROG_BYTE 8'h02
`define FAPI_CMD_READ_BYTE 8'h03
`define FAPI_CMD_ERASE_BVSB 8'h04
`define FAPI_CMD_PROG_LOCK 8'h05
`define FAPI_CMD_PROG_BVH 8'h06
`define FAPI_CMD_READ_MISC 8'h07
`define FAPI_CMD_PROG_STAT 8'h60
`define FAPI_CMD_ZERO_BLK 8'h90
`define FAPI_CMD_ERASE_CHIP 8'h91
`define FAPI_CMD_PROG_BYTE2 8'h92
`define FAPI_CMD_ERASE_BLK2 8'h93
`define FAPI_CMD_PROG_CELL 8'h94
`define FAPI_CMD_ERASE_CELL 8'h95
`define FAPI_CMD_READ_CELL 8'h96
// block selection values in the upper address byte
`define FAPI_BLK0 8'h00
`define FAPI_BLK1 8'h20
`define FAPI_BLK2 8'h40
`define FAPI_BLK3 8'h80
`define FAPI_BLK4 8'hc0
// chip erase follow-up codes
`define FAPI_CHIP_RETURN 8'h55
`define FAPI_CHIP_RESET 8'haa
// special cell addresses
`define FAPI_CELL_BSW_LO 16'h0000
`define FAPI_CELL_BSW_HI 16'h0001
`define FAPI_CELL_BV_LO 16'h0002
`define FAPI_CELL_BV_HI 16'h0003
`define FAPI_CELL_STAT 16'h0004
`define FAPI_CELL_MAKER 16'h0006
`define FAPI_CELL_DEV1 16'h0007
`define FAPI_CELL_DEV2 16'h0008
`define FAPI_CELL_LOCK1 16'h000a
`define FAPI_CELL_LOCK2 16'h000c
`define FAPI_CELL_LOCK3 16'h000e
// identification bytes, values arbitrary
`define FAPI_ID_MAKER 8'h3c
`define FAPI_ID_DEV1 8'ha5
`define FAPI_ID_DEV2 8'h5a
// results
`define FAPI_PASS 8'h00
`define FAPI_FAIL 8'h01
`define FAPI_BAD_CMD 8'hff
// erased cell value and reset values of the special cells
`define FAPI_ERASED 8'hff
`define FAPI_RST_BV 16'hffff
`define FAPI_RST_BSW 16'hffff
`define FAPI_RST_STAT 8'hff
// flash array geometry
`define FAPI_ADDR_W 16
`define FAPI_MEM_DEPTH 65536
// timing: byte step of a sweep is one cycle; program/erase pulse in ns
`define FAPI_PULSE_NS 20
`define FAPI_PULSE_CYC 4'h4

`endif

/* File: hdl/fapi_blk_range.v */
/*
 * decodes a block selection byte into the first and last address of the
 * flash block: two 8k blocks then three 16k blocks.
 * assumes sel comes straight from the upper address byte.
 */
`timescale 1ns/100ps
`include "fapi_defs.vh"

module fapi_blk_range (
    // selection
    input wire [7:0] sel,
    // decoded range
    output reg [15:0] first,
    output reg [15:0] last,
    output reg valid
);

    // only the five documented codes are legal, low bits must be zero
    always @* begin
        valid = 1'b1;
        first = 16'h0000;
        last = 16'h1fff;
        case (sel)
            `FAPI_BLK0: begin
                first = 16'h0000;
                last = 16'h1fff;
            end
            `FAPI_BLK1: begin
                first = 16'h2000;
                last = 16'h3fff;
            end
            `FAPI_BLK2: begin
                first = 16'h4000;
                last = 16'h7fff;
            end
            `FAPI_BLK3: begin
                first = 16'h8000;
                last = 16'hbfff;
            end
            `FAPI_BLK4: begin
                first = 16'hc000;
                last = 16'hffff;
            end
            default: begin
                valid = 1'b0;
            end
        endcase
    end

endmodule

/* File: verif/fapi_checker.sv */
/*
 * checker for the flash maintenance dispatcher: call acceptance, answer
 * timing, result codes and special cell updates.
 * assumes a bind onto fapi_dispatch; one clock, synchronous reset.
 */
`timescale 1ns/100ps
module fapi_checker (
    // clock and reset
    input wire clk,
    input wire rst,
    // call from the processor
    input wire call,
    input wire [15:0] call_target,
    input wire [7:0] command_code_reg,
    input wire [15:0] address_param_reg,
    input wire [7:0] data_result_byte,
    // answer
    input wire busy,
    input wire done,
    input wire [7:0] result_q,
    input wire chip_reset_req,
    // special cells
    input wire [15:0] boot_vector,
    input wire [15:0] boot_status_word,
    input wire [7:0] status_byte,
    input wire lock_bit_one,
    input wire lock_bit_two,
    input wire lock_bit_three
);
    // a call counts only at the entry address while idle
    wire taken = call && (call_target == 16'hfff0) && !busy;
    wire [7:0] cmd = command_code_reg;
    wire [15:0] adr = address_param_reg;
    wire [7:0] bv_lo = boot_vector[7:0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_call_starts: assert property (taken |=> busy)
        else $error("accepted call did not raise busy");
    a_wrong_target: assert property (call && call_target != 16'hfff0 && !busy |=> !busy)
        else $error("call to another target was taken");
    a_short_answer: assert property (taken && (cmd == 8'h00 || cmd == 8'h07)
        |=> !done [*2] ##1 done)
        else $error("short command answer not on third cycle");
    a_read_answer: assert property (taken && cmd == 8'h03 |-> ##4 done)
        else $error("read answer not on fourth cycle");
    a_unknown_cmd: assert property (taken && cmd == 8'h10 |-> ##3 done && result_q == 8'hff)
        else $error("unknown command not refused");
    a_status_write: assert property (taken && cmd == 8'h60 && adr == 16'h0000
        |-> ##3 status_byte == $past(data_result_byte, 3))
        else $error("status byte not written");
    a_bv_high_only: assert property (taken && cmd == 8'h06 && adr == 16'h0001
        |-> ##3 boot_vector == {$past(data_result_byte, 3), $past(bv_lo, 3)})
        else $error("boot vector high write wrong");
    a_lock_report: assert property (taken && cmd == 8'h07 && adr == 16'h0000
        |-> ##3 result_q[3:1] == {lock_bit_three, lock_bit_two, lock_bit_one})
        else $error("lock bits misreported");
    a_cells_erase: assert property (taken && cmd == 8'h04
        |-> ##3 done && boot_vector == 16'hffff && status_byte == 8'hff)
        else $error("boot vector and status not erased");
    a_done_pulse: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_reset_pair: assert property (chip_reset_req |-> done)
        else $error("chip reset request without done");
    c_read: cover property (taken && cmd == 8'h03);
    c_lock: cover property (taken && cmd == 8'h05);
    c_chip: cover property (chip_reset_req);
endmodule

bind fapi_dispatch fapi_checker i_chk (.clk(clk), .rst(rst), .call(call),
    .call_target(call_target), .command_code_reg(command_code_reg),
    .address_param_reg(address_param_reg), .data_result_byte(data_result_byte),
    .busy(busy), .done(done), .result_q(result_q), .chip_reset_req(chip_reset_req),
    .boot_vector(boot_vector), .boot_status_word(boot_status_word),
    .status_byte(status_byte), .lock_bit_one(lock_bit_one),
    .lock_bit_two(lock_bit_two), .lock_bit_three(lock_bit_three));

/* File: verif/fapi_app_model.sv */
/*
 * application program model: loads command, address and data, branches to
 * the entry routine and collects the result byte.
 * assumes the dispatcher clock; drives 1 ns after the rising edge.
 */
`timescale 1ns/100ps
module fapi_app_model (
    // clock and answer
    input wire clk,
    input wire busy,
    input wire done,
    input wire [7:0] result_q,
    input wire chip_reset_req,
    // call
    output reg call = 1'b0,
    output reg [15:0] call_target = 16'h0000,
    output reg [7:0] cmd = 8'h00,
    output reg [15:0] addr = 16'h0000,
    output reg [7:0] data = 8'h00
);
    // call strobe for one cycle, inputs held until done; inputs scrambled afterwards so stale values never help
    task automatic run(input [15:0] tgt, input [7:0] c, input [15:0] a, input [7:0] d,
        input integer lim, output [7:0] res, output rr, output ok);
        integer n;
        begin
            n = 0;
            @(posedge clk);
            #1;
            while (busy !== 1'b0) begin
                @(posedge clk);
                #1;
            end
            call = 1'b1;
            call_target = tgt;
            cmd = c;
            addr = a;
            data = d;
            @(posedge clk);
            #1;
            call = 1'b0;
            while (n < lim && done !== 1'b1) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
            ok = (done === 1'b1);
            res = result_q;
            rr = chip_reset_req;
            call_target = ~call_target;
            cmd = ~cmd;
            addr = ~addr;
            data = ~data;
        end
    endtask
endmodule

/* File: verif/testbench.sv */
/*
 * self-checking bench for the flash maintenance dispatcher.
 * assumes the application model and the bound checker.
 */
`timescale 1ns/100ps
`include "fapi_defs.vh"
module testbench;
    reg clk, rst = 1'b1;
    wire call, busy, done, chip_reset_req, lock_bit_one, lock_bit_two, lock_bit_three;
    wire [15:0] call_target, address_param_reg, boot_vector, boot_status_word;
    wire [7:0] command_code_reg, data_result_byte, result_q, status_byte;
    integer errors = 0;
    integer total_checks = 0;
    integer cyc = 0, i;
    reg [7:0] res;
    reg rr, ok;
    reg [7:0] ids [0:2];

    fapi_dispatch i_fapi_dispatch (.clk(clk), .rst(rst), .call(call),
        .call_target(call_target), .command_code_reg(command_code_reg),
        .address_param_reg(address_param_reg), .data_result_byte(data_result_byte),
        .busy(busy), .done(done), .result_q(result_q), .chip_reset_req(chip_reset_req),
        .boot_vector(boot_vector), .boot_status_word(boot_status_word),
        .status_byte(status_byte), .lock_bit_one(lock_bit_one),
        .lock_bit_two(lock_bit_two), .lock_bit_three(lock_bit_three));
    fapi_app_model i_app (.clk(clk), .busy(busy), .done(done), .result_q(result_q),
        .chip_reset_req(chip_reset_req), .call(call), .call_target(call_target),
        .cmd(command_code_reg), .addr(address_param_reg), .data(data_result_byte));

    // compares
    task chk8(input [7:0] got, input [7:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task chk16(input [15:0] got, input [15:0] exp);
        begin
            chk8(got[15:8], exp[15:8]);
            chk8(got[7:0], exp[7:0]);
        end
    endtask
    // a call at the entry address that must complete
    task op(input [7:0] c, input [15:0] a, input [7:0] d);
        begin
            i_app.run(16'hfff0, c, a, d, 70000, res, rr, ok);
            chk8({7'h00, ok}, 8'h01);
        end
    endtask

    task t_ids;
        begin
            for (i = 0; i < 3; i = i + 1) begin
                op(8'h00, i[15:0], 8'h00);
                chk8(res, ids[i]);
                op(8'h96, 16'h0006 + i[15:0], 8'h00);
                chk8(res, ids[i]);
            end
            $display("test ids done");
        end
    endtask
    task t_cells;
        begin
            op(8'h04, 16'h0000, 8'h00);
            chk8(res, 8'h00);
            chk16(boot_vector, 16'hffff);
            op(8'h06, 16'h0001, 8'h12);
            chk16(boot_vector, 16'h12ff);
            op(8'h60, 16'h0000, 8'h5c);
            chk8(status_byte, 8'h5c);
            op(8'h07, 16'h0001, 8'h00);
            chk8(res, 8'h5c);
            op(8'h96, 16'h0004, 8'h00);
            chk8(res, 8'h5c);
            op(8'h94, 16'h0000, 8'h77);
            chk16(boot_status_word, 16'hff77);
            op(8'h95, 16'h0000, 8'h00);
            chk16(boot_status_word, 16'hffff);
            $display("test cells done");
        end
    endtask
    task t_array;
        begin
            op(8'h02, 16'h1234, 8'ha5);
            chk8(res, `FAPI_PASS);
            op(8'h03, 16'h1234, 8'h00);
            chk8(res, 8'ha5);
            op(8'h92, 16'h3456, 8'h5a);
            op(8'h03, 16'h3456, 8'h00);
            chk8(res, 8'h5a);
            $display("test array done");
        end
    endtask
    // zero then erase block 0; block 1 must keep its byte
    task t_block;
        begin
            op(8'h01, 16'h1000, 8'h00);
            chk8(res, `FAPI_FAIL);
            op(8'h90, 16'h0000, 8'h00);
            op(8'h03, 16'h0100, 8'h00);
            chk8(res, 8'h00);
            op(8'h93, 16'h0000, 8'h00);
            chk8(res, `FAPI_PASS);
            op(8'h03, 16'h0100, 8'h00);
            chk8(res, 8'hff);
            op(8'h03, 16'h0000, 8'h00);
            chk8(res, 8'hff);
            op(8'h03, 16'h3456, 8'h00);
            chk8(res, 8'h5a);
            $display("test block done");
        end
    endtask
    task t_locks;
        begin
            for (i = 0; i < 3; i = i + 1) begin
                op(8'h05, i[15:0], 8'h00);
                chk8({5'h00, lock_bit_three, lock_bit_two, lock_bit_one}, (8'h02 << i) - 8'h01);
            end
            op(8'h07, 16'h0000, 8'h00);
            chk8(res & 8'h0e, 8'h0e);
            op(8'h02, 16'h0200, 8'h11);
            chk8(res, `FAPI_FAIL);
            $display("test locks done");
        end
    endtask
    task t_bad;
        begin
            i_app.run(16'hfff1, 8'h03, 16'h0000, 8'h00, 10, res, rr, ok);
            chk8({7'h00, ok}, 8'h00);
            op(8'h10, 16'h0000, 8'h00);
            chk8(res, `FAPI_BAD_CMD);
            op(8'h91, 16'h0000, 8'h12);
            chk8(res, `FAPI_FAIL);
            $display("test bad done");
        end
    endtask
    // long sweep of the whole array, kept last
    task t_chip;
        begin
            op(8'h91, 16'h0000, 8'haa);
            chk8({7'h00, rr}, 8'h01);
            chk8({5'h00, lock_bit_three, lock_bit_two, lock_bit_one}, 8'h00);
            chk16(boot_vector, 16'hffff);
            $display("test chip done");
        end
    endtask

    task results;
        begin
            $display("checks %0d mismatches %0d", total_checks, errors);
            if (errors == 0 && total_checks > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // hang guard above chip erase plus two sweeps
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 100000) begin
            errors = errors + 1;
            results;
        end
    end
    // main sequence
    initial begin
        ids[0] = `FAPI_ID_MAKER;
        ids[1] = `FAPI_ID_DEV1;
        ids[2] = `FAPI_ID_DEV2;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        t_ids;
        t_cells;
        t_array;
        t_block;
        t_locks;
        t_bad;
        t_chip;
        results;
    end
endmodule
